//--- rtl/scpt_top.sv
// Purpose: Oscillator trim, start-up delay, clock output and protected system prescaler
// Assumes: Fuses are static; pins are sampled through two flops
// Notes: Divided clock is delivered as a one-cycle enable pulse
//
// Contract
// - Load factory trim byte during reset; code holds 0x80 in reset and loads the byte on the first cycle after it
// - Trim top bit selects low/high range
// - Low seven trim bits tune within range
// - Fuse code 0000 selects external clock
// - Start-up delays per start-up fuse code
// - Clock-out fuse drives clock on pin
// - Clock-out pin carries divided clock; at division code 0 the pin toggles each cycle, half the clock rate
// - Timer oscillator only with internal RC
// - Timer external-clock bit selects clock input
// - Prescaler divides all system clocks
// - Change-enable set only with others zero
// - Change-enable clears after four cycles
// - Rewrite neither restarts nor clears window
// - Division write accepted only in window
// - Division reset value from divide-eight fuse
// - Any division value writable regardless fuse
// - Division is two to the code
// - Switching divisions is glitch-free
// - New division active within bounded time
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module scpt_top #(
  parameter int SHORT_DELAY_CYC = scpt_pkg::DELAY_SHORT_CYC,
  parameter int LONG_DELAY_CYC = scpt_pkg::DELAY_LONG_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port
  input wire scpt_pkg::scpt_bus_s bus,
  output logic [7:0] rdata,
  // Fuses and factory data
  input wire scpt_pkg::scpt_fuse_s fuses,
  input wire logic [7:0] factory_trim,
  input wire logic wake_request,
  // Pins
  input wire logic crystal_in_pin,
  input wire logic timer_osc_in_pin,
  output logic clock_out_pin,
  output logic clock_out_pin_oe_n,
  // Clock results
  output logic sys_clock_en,
  output logic core_ready,
  output logic use_external_clock,
  output logic [7:0] osc_trim_out,
  output logic timer_osc_enable,
  output logic timer_clock_in
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [1:0] xtal_sync_reg;
  logic [1:0] tosc_sync_reg;
  always_ff @(posedge clock) begin
    xtal_sync_reg <= {xtal_sync_reg[0], crystal_in_pin};
    tosc_sync_reg <= {tosc_sync_reg[0], timer_osc_in_pin};
  end

  // ****************************************
  // Oscillator trim
  // ****************************************
  logic [7:0] osc_trim_reg;
  logic trim_loaded_reg;
  always_ff @(posedge clock) begin
    if (reset) begin
      trim_loaded_reg <= 1'b0;
      osc_trim_reg <= scpt_pkg::TRIM_FACTORY_DEFAULT;
    end else if (!trim_loaded_reg) begin
      trim_loaded_reg <= 1'b1;
      osc_trim_reg <= factory_trim;
    end else if (bus.wr && bus.addr == scpt_pkg::OFS_TRIM) begin
      // Bit 7 range, bits 6..0 fine step; analog side decodes
      osc_trim_reg <= bus.wdata;
    end
  end
  always_ff @(posedge clock) begin
    osc_trim_out <= osc_trim_reg;
  end

  // ****************************************
  // Timer oscillator
  // ****************************************
  logic timer_ext_reg;
  always_ff @(posedge clock) begin
    if (reset) begin
      timer_ext_reg <= 1'b0;
    end else if (bus.wr && bus.addr == scpt_pkg::OFS_TIMER_STAT) begin
      timer_ext_reg <= bus.wdata[scpt_pkg::TIMER_EXT_BIT];
    end
  end
  logic rc_selected;
  assign rc_selected = fuses.source == scpt_pkg::SRC_INTERNAL_RC;
  always_ff @(posedge clock) begin
    if (reset) begin
      timer_osc_enable <= 1'b0;
      timer_clock_in <= 1'b0;
    end else begin
      timer_osc_enable <= rc_selected;
      // Gated to zero when pins belong to the main clock
      timer_clock_in <= rc_selected && timer_ext_reg && tosc_sync_reg[1];
    end
  end

  // ****************************************
  // Start-up delay
  // ****************************************
  scpt_pkg::scpt_state_e state_reg;
  logic [31:0] start_cnt_reg;
  logic [31:0] start_target;
  always_comb begin
    unique case (fuses.startup)
      2'b00: start_target = 32'(scpt_pkg::BASE_DELAY_CK);
      2'b01: start_target = 32'(scpt_pkg::BASE_DELAY_CK + SHORT_DELAY_CYC);
      2'b10: start_target = 32'(scpt_pkg::BASE_DELAY_CK + LONG_DELAY_CYC);
      // Reserved code treated as the longest delay
      default: start_target = 32'(scpt_pkg::BASE_DELAY_CK + LONG_DELAY_CYC);
    endcase
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= scpt_pkg::SCPT_ST_START;
      start_cnt_reg <= 32'h0;
      core_ready <= 1'b0;
    end else begin
      unique case (state_reg)
        scpt_pkg::SCPT_ST_START: begin
          start_cnt_reg <= start_cnt_reg + 32'h1;
          if (start_cnt_reg + 32'h1 >= start_target) begin
            state_reg <= scpt_pkg::SCPT_ST_RUN;
            core_ready <= 1'b1;
          end
        end
        scpt_pkg::SCPT_ST_RUN: begin
          if (wake_request) begin
            state_reg <= scpt_pkg::SCPT_ST_WAKE;
            start_cnt_reg <= 32'h0;
            core_ready <= 1'b0;
          end
        end
        scpt_pkg::SCPT_ST_WAKE: begin
          start_cnt_reg <= start_cnt_reg + 32'h1;
          if (start_cnt_reg + 32'h1 >= 32'(scpt_pkg::SLEEP_WAKE_CK)) begin
            state_reg <= scpt_pkg::SCPT_ST_RUN;
            core_ready <= 1'b1;
          end
        end
        // Unused code: back to start-up, with the count and core_ready kept, rather than hang
        default: state_reg <= scpt_pkg::SCPT_ST_START;
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      use_external_clock <= 1'b0;
    end else begin
      use_external_clock <= fuses.source == scpt_pkg::SRC_EXTERNAL;
    end
  end

  // ****************************************
  // Prescale register
  // ****************************************
  logic pce_reg;
  logic [2:0] pce_cnt_reg;
  logic [3:0] div_reg;
  logic div_loaded_reg;
  logic presc_wr;
  assign presc_wr = bus.wr && bus.addr == scpt_pkg::OFS_PRESCALE;
  always_ff @(posedge clock) begin
    if (reset) begin
      pce_reg <= 1'b0;
      pce_cnt_reg <= 3'h0;
    end else if (presc_wr && !bus.wdata[scpt_pkg::PCE_BIT] && pce_reg) begin
      pce_reg <= 1'b0;
      pce_cnt_reg <= 3'h0;
    end else if (presc_wr && bus.wdata == 8'h80 && !pce_reg) begin
      pce_reg <= 1'b1;
      pce_cnt_reg <= scpt_pkg::PCE_WINDOW_CYCLES - 3'h1;
    end else if (pce_reg) begin
      // A rewrite of 0x80 lands here and the count keeps running down
      if (pce_cnt_reg == 3'h0) begin
        pce_reg <= 1'b0;
      end else begin
        pce_cnt_reg <= pce_cnt_reg - 3'h1;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      div_loaded_reg <= 1'b0;
      div_reg <= scpt_pkg::DIV_RESET_PLAIN;
    end else if (!div_loaded_reg) begin
      div_loaded_reg <= 1'b1;
      div_reg <= fuses.div8 ? scpt_pkg::DIV_RESET_DIV8 : scpt_pkg::DIV_RESET_PLAIN;
    end else if (presc_wr && pce_reg && !bus.wdata[scpt_pkg::PCE_BIT]) begin
      div_reg <= bus.wdata[3:0];
    end
  end

  // ****************************************
  // Divider
  // ****************************************
  // Reserved codes clamp to the largest divide
  function automatic logic [8:0] div_span(input logic [3:0] code);
    logic [3:0] c;
    c = (code > scpt_pkg::DIV_MAX_CODE) ? scpt_pkg::DIV_MAX_CODE : code;
    return 9'(9'h1 << c);
  endfunction
  logic [8:0] div_cnt_reg;
  logic [8:0] span_reg;
  logic clk_phase_reg;
  always_ff @(posedge clock) begin
    if (reset) begin
      div_cnt_reg <= 9'h0;
      span_reg <= 9'h1;
      sys_clock_en <= 1'b0;
    end else begin
      sys_clock_en <= 1'b0;
      if (div_cnt_reg + 9'h1 >= span_reg) begin
        div_cnt_reg <= 9'h0;
        sys_clock_en <= 1'b1;
        // New span only at a period boundary: no short period appears
        span_reg <= div_span(div_reg);
      end else begin
        div_cnt_reg <= div_cnt_reg + 9'h1;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      clk_phase_reg <= 1'b0;
    end else if (span_reg == 9'h1) begin
      clk_phase_reg <= ~clk_phase_reg;
    end else begin
      clk_phase_reg <= div_cnt_reg < (span_reg >> 1);
    end
  end

  // ****************************************
  // Clock output pin
  // ****************************************
  always_ff @(posedge clock) begin
    // Driven during reset too; fuse is static
    clock_out_pin_oe_n <= !fuses.clock_out;
    clock_out_pin <= fuses.clock_out && clk_phase_reg;
  end

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata <= 8'h0;
    end else if (bus.rd) begin
      unique case (bus.addr)
        scpt_pkg::OFS_TRIM: rdata <= osc_trim_reg;
        scpt_pkg::OFS_PRESCALE: rdata <= {pce_reg, 3'h0, div_reg};
        scpt_pkg::OFS_TIMER_STAT: rdata <= {3'h0, timer_ext_reg, 4'h0};
        scpt_pkg::OFS_STATUS: rdata <= {5'h0, xtal_sync_reg[1], use_external_clock, core_ready};
        default: rdata <= 8'h0;
      endcase
    end else begin
      rdata <= 8'h0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_pce_timeout;
    @(posedge clock) disable iff (reset)
    (presc_wr && bus.wdata == 8'h80 && !pce_reg)
      ##1 (!(presc_wr && !bus.wdata[scpt_pkg::PCE_BIT])) [*4] |-> pce_reg ##1 !pce_reg;
  endproperty
  a_pce_timeout: assert property (p_pce_timeout) else $error("Change enable timing wrong");

  property p_pce_needs_zero;
    @(posedge clock) disable iff (reset)
    (!pce_reg && presc_wr && bus.wdata != 8'h80) |=> !pce_reg;
  endproperty
  a_pce_needs_zero: assert property (p_pce_needs_zero) else $error("Change enable set wrongly");

  property p_div_guard;
    @(posedge clock) disable iff (reset)
    (div_loaded_reg && !(presc_wr && pce_reg)) |=> $stable(div_reg);
  endproperty
  a_div_guard: assert property (p_div_guard) else $error("Division changed outside window");

  property p_div_write;
    @(posedge clock) disable iff (reset)
    (div_loaded_reg && presc_wr && pce_reg && !bus.wdata[7]) |=> !pce_reg && div_reg == $past(bus.wdata[3:0]);
  endproperty
  a_div_write: assert property (p_div_write) else $error("Division write lost");

  property p_span_change;
    @(posedge clock) disable iff (reset)
    $changed(span_reg) |-> sys_clock_en;
  endproperty
  a_span_change: assert property (p_span_change) else $error("Span changed mid period");

  property p_wake;
    @(posedge clock) disable iff (reset)
    (state_reg == scpt_pkg::SCPT_ST_RUN && wake_request) |=> !core_ready [*6] ##1 core_ready;
  endproperty
  a_wake: assert property (p_wake) else $error("Wake delay wrong");

  property p_clock_out;
    @(posedge clock) !fuses.clock_out |=> clock_out_pin_oe_n && !clock_out_pin;
  endproperty
  a_clock_out: assert property (p_clock_out) else $error("Clock pin driven without fuse");

  property p_timer_gate;
    @(posedge clock) disable iff (reset)
    !rc_selected |=> !timer_osc_enable && !timer_clock_in;
  endproperty
  a_timer_gate: assert property (p_timer_gate) else $error("Timer oscillator not gated");

  property p_trim_load;
    @(posedge clock) disable iff (reset)
    !trim_loaded_reg |=> osc_trim_reg == $past(factory_trim);
  endproperty
  a_trim_load: assert property (p_trim_load) else $error("Factory trim not loaded");

  property p_div_reset;
    @(posedge clock) disable iff (reset)
    !div_loaded_reg |=> div_reg == ($past(fuses.div8) ? scpt_pkg::DIV_RESET_DIV8 : 4'h0);
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("Division reset value wrong");

  property p_span_code;
    @(posedge clock) disable iff (reset)
    (sys_clock_en && $past(div_reg) <= scpt_pkg::DIV_MAX_CODE)
      |-> span_reg == (9'h1 << $past(div_reg));
  endproperty
  a_span_code: assert property (p_span_code) else $error("Division not a power of two");

  property p_div_take;
    @(posedge clock) disable iff (reset)
    (div_loaded_reg && !$stable(div_reg)) |-> ##[0:257] span_reg == div_span(div_reg);
  endproperty
  a_div_take: assert property (p_div_take) else $error("New division not taken in time");

  property p_prescale_read;
    @(posedge clock) disable iff (reset)
    (bus.rd && bus.addr == scpt_pkg::OFS_PRESCALE) |=> rdata == {$past(pce_reg), 3'h0, $past(div_reg)};
  endproperty
  a_prescale_read: assert property (p_prescale_read) else $error("Prescale read wrong");

  property p_source;
    @(posedge clock) disable iff (reset)
    1'b1 |=> use_external_clock == ($past(fuses.source) == scpt_pkg::SRC_EXTERNAL);
  endproperty
  a_source: assert property (p_source) else $error("External source flag wrong");

  c_window_rewrite: cover property (@(posedge clock) pce_reg && presc_wr && bus.wdata == 8'h80);

  c_prescale_change: cover property (@(posedge clock) pce_reg ##1 (presc_wr && pce_reg));
  c_pce_expire: cover property (@(posedge clock) pce_reg ##1 !pce_reg && !presc_wr);
  c_wake: cover property (@(posedge clock) state_reg == scpt_pkg::SCPT_ST_WAKE);

endmodule
`default_nettype wire

//--- rtl/scpt_pkg.sv
// Purpose: Shared constants and types for the clock prescale and trim block
// Assumes: 125 MHz system clock, registers on a plain strobe port
// Notes: Offsets are local choices; no bus standard applies
package scpt_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] OFS_TRIM = 4'h0;
  localparam logic [3:0] OFS_PRESCALE = 4'h1;
  localparam logic [3:0] OFS_TIMER_STAT = 4'h2;
  localparam logic [3:0] OFS_STATUS = 4'h3;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int PCE_BIT = 7;
  localparam logic [3:0] DIV_RESET_PLAIN = 4'h0;
  localparam logic [3:0] DIV_RESET_DIV8 = 4'h3;
  localparam logic [3:0] DIV_MAX_CODE = 4'h8;
  localparam logic [3:0] SRC_EXTERNAL = 4'h0;
  localparam logic [3:0] SRC_INTERNAL_RC = 4'h2;
  localparam logic [7:0] TRIM_FACTORY_DEFAULT = 8'h80;
  localparam int TIMER_EXT_BIT = 4;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLOCK_MHZ = 125;
  localparam logic [2:0] PCE_WINDOW_CYCLES = 3'h4;
  localparam int BASE_DELAY_CK = 14;
  localparam int SLEEP_WAKE_CK = 6;
  localparam int DELAY_SHORT_US = 4100;
  localparam int DELAY_LONG_US = 65000;
  localparam int DELAY_SHORT_CYC = DELAY_SHORT_US * CLOCK_MHZ;
  localparam int DELAY_LONG_CYC = DELAY_LONG_US * CLOCK_MHZ;

  typedef enum logic [1:0] {
    SCPT_ST_START,
    SCPT_ST_RUN,
    SCPT_ST_WAKE
  } scpt_state_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } scpt_bus_s;

  typedef struct packed {
    logic [3:0] source;
    logic [1:0] startup;
    logic clock_out;
    logic div8;
  } scpt_fuse_s;

endpackage

//--- sim/scpt_top_test.sv
// Purpose: Self-checking bench for the clock prescale and trim block
// Assumes: Register port as in the package; short start-up delays of 20 and 40 cycles
// Notes: Strobes may stay high between back-to-back writes; idle() releases them
`timescale 1ns/1ps
`default_nettype none
module scpt_top_test;
  localparam int SHORT_CYC = 20;
  localparam int LONG_CYC = 40;

  // Clock and reset
  logic clock;
  logic reset;
  // Register port
  scpt_pkg::scpt_bus_s bus;
  logic [7:0] rdata;
  // Fuses and pins
  scpt_pkg::scpt_fuse_s fuses;
  logic [7:0] factory_trim;
  logic wake_request;
  logic crystal_in_pin;
  logic timer_osc_in_pin;
  logic clock_out_pin;
  logic clock_out_pin_oe_n;
  // Results
  logic sys_clock_en;
  logic core_ready;
  logic use_external_clock;
  logic [7:0] osc_trim_out;
  logic timer_osc_enable;
  logic timer_clock_in;
  int n_mismatch = 0;
  int checks_done = 0;

  scpt_top #(.SHORT_DELAY_CYC(SHORT_CYC), .LONG_DELAY_CYC(LONG_CYC)) u_scpt_top (
    .clock(clock), .reset(reset), .bus(bus), .rdata(rdata), .fuses(fuses),
    .factory_trim(factory_trim), .wake_request(wake_request),
    .crystal_in_pin(crystal_in_pin), .timer_osc_in_pin(timer_osc_in_pin),
    .clock_out_pin(clock_out_pin), .clock_out_pin_oe_n(clock_out_pin_oe_n),
    .sys_clock_en(sys_clock_en), .core_ready(core_ready),
    .use_external_clock(use_external_clock), .osc_trim_out(osc_trim_out),
    .timer_osc_enable(timer_osc_enable), .timer_clock_in(timer_clock_in)
  );

  always #4 clock = ~clock;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic report_and_stop();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask

  // Leaves the strobe high so a following write lands back to back
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus <= '0;
    #1;
    chk("rdata", {8'h00, exp}, {8'h00, rdata});
  endtask

  task automatic idle(input int n);
    bus <= '0;
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic start(input scpt_pkg::scpt_fuse_s f, input int exp_dly);
    int c;
    fuses <= f;
    reset <= 1'b1;
    bus <= '0;
    repeat (12) @(posedge clock);
    #1;
    chk("oe_n in reset", {15'h0, ~f.clock_out}, {15'h0, clock_out_pin_oe_n});
    reset <= 1'b0;
    c = 0;
    while (core_ready !== 1'b1 && c < 300) begin
      @(posedge clock);
      #1;
      c++;
    end
    chk("startup span", 16'(exp_dly), 16'(c));
  endtask

  // Interval between enable pulses and, for codes above 0, between pin rises, after switching settles
  task automatic period(input int code);
    int c;
    int k;
    for (k = 0; k < 4; k++) begin
      c = 0;
      do begin
        @(posedge clock);
        #1;
        c++;
      end while (sys_clock_en !== 1'b1 && c < 600);
    end
    chk("enable period", 16'(1 << code), 16'(c));
    if (code > 0) begin
      c = 0;
      while (clock_out_pin !== 1'b0 && c < 600) begin
        @(posedge clock);
        #1;
        c++;
      end
      while (clock_out_pin !== 1'b1 && c < 600) begin
        @(posedge clock);
        #1;
        c++;
      end
      // Rise to next rise: wait for the fall, then the rise
      c = 0;
      do begin
        @(posedge clock);
        #1;
        c++;
      end while (clock_out_pin !== 1'b0 && c < 600);
      while (clock_out_pin !== 1'b1 && c < 600) begin
        @(posedge clock);
        #1;
        c++;
      end
      chk("pin period", 16'(1 << code), 16'(c));
    end
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    bus = '0;
    fuses = '0;
    factory_trim = 8'h5a;
    wake_request = 1'b0;
    crystal_in_pin = 1'b0;
    timer_osc_in_pin = 1'b0;
    start('{source: 4'h2, startup: 2'h1, clock_out: 1'b1, div8: 1'b1}, 14 + SHORT_CYC);
    rd(scpt_pkg::OFS_TRIM, 8'h5a);
    chk("trim out", 16'h005a, {8'h00, osc_trim_out});
    rd(scpt_pkg::OFS_PRESCALE, 8'h03);
    wr(scpt_pkg::OFS_TRIM, 8'h7f);
    rd(scpt_pkg::OFS_TRIM, 8'h7f);
    wr(scpt_pkg::OFS_TRIM, 8'h80);
    rd(scpt_pkg::OFS_TRIM, 8'h80);
    chk("trim out", 16'h0080, {8'h00, osc_trim_out});
    chk("timer osc en", 16'h1, {15'h0, timer_osc_enable});
    chk("external", 16'h0, {15'h0, use_external_clock});
    wr(scpt_pkg::OFS_PRESCALE, 8'h90);
    rd(scpt_pkg::OFS_PRESCALE, 8'h03);
    wr(scpt_pkg::OFS_PRESCALE, 8'h80);
    rd(scpt_pkg::OFS_PRESCALE, 8'h83);
    idle(5);
    // Window lapsed after four cycles
    wr(scpt_pkg::OFS_PRESCALE, 8'h80);
    idle(4);
    wr(scpt_pkg::OFS_PRESCALE, 8'h05);
    idle(1);
    rd(scpt_pkg::OFS_PRESCALE, 8'h03);
    // Rewrite must not stretch the window
    wr(scpt_pkg::OFS_PRESCALE, 8'h80);
    idle(2);
    wr(scpt_pkg::OFS_PRESCALE, 8'h80);
    idle(1);
    wr(scpt_pkg::OFS_PRESCALE, 8'h05);
    idle(1);
    rd(scpt_pkg::OFS_PRESCALE, 8'h03);
    // Rewrite must not close the window
    wr(scpt_pkg::OFS_PRESCALE, 8'h80);
    wr(scpt_pkg::OFS_PRESCALE, 8'h80);
    wr(scpt_pkg::OFS_PRESCALE, 8'h05);
    idle(1);
    rd(scpt_pkg::OFS_PRESCALE, 8'h05);
    // Every code 0 to 8, written at the last cycle of the window, with unused bits set
    for (int code = 0; code <= 8; code++) begin
      wr(scpt_pkg::OFS_PRESCALE, 8'h80);
      idle(3);
      wr(scpt_pkg::OFS_PRESCALE, {4'h7, 4'(code)});
      idle(1);
      rd(scpt_pkg::OFS_PRESCALE, {4'h0, 4'(code)});
      period(code);
    end
    wr(scpt_pkg::OFS_TIMER_STAT, 8'h10);
    rd(scpt_pkg::OFS_TIMER_STAT, 8'h10);
    timer_osc_in_pin <= 1'b1;
    idle(5);
    chk("timer clock", 16'h1, {15'h0, timer_clock_in});
    timer_osc_in_pin <= 1'b0;
    idle(5);
    chk("timer clock", 16'h0, {15'h0, timer_clock_in});
    wr(4'h5, 8'hff);
    rd(4'h5, 8'h00);
    rd(scpt_pkg::OFS_TRIM, 8'h80);
    crystal_in_pin <= 1'b1;
    idle(4);
    rd(scpt_pkg::OFS_STATUS, 8'h05);
    wake_request <= 1'b1;
    idle(1);
    wake_request <= 1'b0;
    chk("ready in wake", 16'h0, {15'h0, core_ready});
    idle(5);
    chk("ready in wake", 16'h0, {15'h0, core_ready});
    idle(1);
    chk("ready after wake", 16'h1, {15'h0, core_ready});
    // Second power-up: external source, long delay, fuses clear
    start('{source: 4'h0, startup: 2'h2, clock_out: 1'b0, div8: 1'b0}, 14 + LONG_CYC);
    chk("external", 16'h1, {15'h0, use_external_clock});
    chk("timer osc en", 16'h0, {15'h0, timer_osc_enable});
    chk("pin idle", 16'h0, {15'h0, clock_out_pin});
    rd(scpt_pkg::OFS_PRESCALE, 8'h00);
    wr(scpt_pkg::OFS_TIMER_STAT, 8'h10);
    idle(1);
    timer_osc_in_pin <= 1'b1;
    idle(5);
    chk("timer clock", 16'h0, {15'h0, timer_clock_in});
    // Shortest and reserved start-up codes; reserved takes the long delay
    start('{source: 4'h2, startup: 2'h0, clock_out: 1'b0, div8: 1'b1}, 14);
    rd(scpt_pkg::OFS_PRESCALE, 8'h03);
    start('{source: 4'h0, startup: 2'h3, clock_out: 1'b1, div8: 1'b0}, 14 + LONG_CYC);
    rd(scpt_pkg::OFS_PRESCALE, 8'h00);
    report_and_stop();
  end

  initial begin
    #160000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
`default_nettype wire
